/* File: sar_adc_sequencer_test.sv */
// sar_adc_sequencer_test: self-checking bench for the sequencer.
// assumes a behavioural sar core returning codes chosen by the bench.
`timescale 1ns/1ps
module sar_adc_sequencer_test import sas_pkg::*; ;
  logic        clk = 0, rst = 1, cnv = 0, clr = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rv, rd_d, ctl = 0;
  logic [1:0]  rr, br, rrs;
  logic [11:0] code = 0, c, scode;
  logic        awr, wrr, bv, arr, rvl, pwr_o, trk_o, cv_o;
  logic [12:0] gain;
  integer      err_total = 0, total_checks = 0, seed = 32'h98157795;
  int          trk_n, cnv_n, lat_n, lat0, cv0, la, hi, q[$];

  sas_seq i_sas_seq (
    .sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rvl),
    .s_axi_rready_i(rry), .cnv_start_i(cnv), .sar_code_i(scode),
    .sar_power_o(pwr_o), .sar_track_o(trk_o), .sar_convert_o(cv_o),
    .gain_word_o(gain));

  sas_sar_model i_sas_sar_model (.sys_clk_i(clk), .convert_i(cv_o),
    .code_i(code), .sar_code_o(scode));

  initial begin
    forever #20 clk = ~clk;
  end

  // tracking, conversion and start latency counts
  always @(posedge clk) begin
    trk_n <= clr ? 0 : trk_n + trk_o;
    cnv_n <= clr ? 0 : cnv_n + cv_o;
    lat_n <= clr ? 0 : lat_n + (cnv_n == 0);
  end

  task chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wrr !== 1'b1);
        wv <= 1'b0;
      end
    join
    bry <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rry <= 1'b1;
    do @(posedge clk); while (rvl !== 1'b1);
    rry <= 1'b0;
    rv = rd_d;
    rr = rrs;
  endtask

  // one start; n samples of one code join the model's series
  task run(input int n, input bit last);
    int s;
    c = {1'b1, 11'($random(seed))};
    code <= c;
    repeat (n) q.push_back(c);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cnv <= 1'b1;
    @(posedge clk);
    cnv <= 1'b0;
    do @(posedge clk); while (cnv_n == 0 || cv_o !== 1'b0);
    do rd(SAS_CTRL_OFS); while (last && rv[4] !== 1'b0);
    chk("done", rv[5], last);
    chk("window", rv[1], last);
    if (last) begin
      s = q.sum();
      if (q.size() == 1 && ctl[2]) s = s << 4;
      q.delete();
      rd(SAS_RESH_OFS);
      hi = rv << 8;
      rd(SAS_RESL_OFS);
      chk("result", hi | rv, s);
      wr(SAS_CTRL_OFS, ctl | 32'h22);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SAS_CFG_OFS);
    chk("cfg", rv, 32'hF8);
    chk("rresp_ok", rr, SAS_RESP_OK);
    rd(SAS_MODE_OFS);
    chk("mode", rv, 32'hF01);
    rd(SAS_WLIM_OFS);
    chk("wlim", rv, 32'hFFFF0000);
    rd(8'h3C);
    chk("unmapped", rr, SAS_RESP_DEC);
    chk("gain_rst", gain, 13'h1F81);
    $display("test reset done");
    wr(SAS_WLIM_OFS, 32'h01000000);
    chk("bresp_ok", br, SAS_RESP_OK);
    wr(8'h3C, 32'h0);
    chk("bresp_dec", br, SAS_RESP_DEC);
    // converter enabled so idle tracking differs between modes
    ctl = 32'h1;
    wr(SAS_CTRL_OFS, ctl);
    for (int i = 0; i < 4; i++) begin
      wr(SAS_CFG_OFS, (i / 2) << 3);
      wr(SAS_MODE_OFS, 3 * (i % 2) << 2 | 1);
      run(1, 1);
      chk("track_len", trk_n, 3 * (i % 2) + 2);
      chk("post_idle", trk_o, 0);
      if (i == 0) begin
        lat0 = lat_n;
        cv0 = cnv_n;
      end
      if (i == 2) chk("sar_ticks", cnv_n - cv0, 13);
    end
    wr(SAS_CFG_OFS, 0);
    wr(SAS_MODE_OFS, SAS_TM_PRE);
    run(1, 1);
    chk("pre_lat", lat_n + 2, lat0);
    chk("pre_conv", cnv_n, cv0);
    wr(SAS_MODE_OFS, SAS_TM_DUAL);
    run(1, 1);
    chk("dual_idle", trk_o, 1);
    $display("test timing done");
    ctl = 32'h4;
    wr(SAS_CTRL_OFS, ctl);
    run(1, 1);
    ctl = 0;
    wr(SAS_CTRL_OFS, ctl);
    wr(SAS_CFG_OFS, 32'h2);
    repeat (3) run(1, 0);
    run(1, 1);
    $display("test accumulate done");
    wr(SAS_CFG_OFS, 32'h6);
    wr(SAS_MODE_OFS, 32'h341);
    run(16, 1);
    la = lat_n;
    chk("power_down", pwr_o, 0);
    ctl = 1;
    wr(SAS_CTRL_OFS, ctl);
    wr(SAS_CFG_OFS, 32'h2);
    run(4, 1);
    chk("power_on", pwr_o, 1);
    chk("power_up", (la - lat_n) inside {[7:9]}, 1);
    $display("test burst done");
    wr(SAS_CFG_OFS, 32'h1);
    wr(SAS_RESH_OFS, SAS_GAIN_HI_IDX);
    wr(SAS_RESL_OFS, 32'h6C);
    wr(SAS_RESH_OFS, SAS_GAIN_LO_IDX);
    wr(SAS_RESL_OFS, 32'hA0);
    wr(SAS_RESH_OFS, SAS_GAIN_ADD_IDX);
    wr(SAS_RESL_OFS, 32'h0);
    chk("gain", gain, 13'h0D94);
    $display("test gain done");
    report_and_stop;
  end
endmodule

/* File: sas_pkg.sv */
// sas_pkg: register map, field positions, resets and states of the
// converter sequencer; shared by the sequencer and its tick divider.
package sas_pkg;

  // register byte offsets on the AXI4-Lite port
  localparam logic [7:0] SAS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SAS_CFG_OFS  = 8'h04;
  localparam logic [7:0] SAS_MODE_OFS = 8'h08;
  localparam logic [7:0] SAS_RESH_OFS = 8'h0C;
  localparam logic [7:0] SAS_RESL_OFS = 8'h10;
  localparam logic [7:0] SAS_WLIM_OFS = 8'h14;

  // converter_control_reg fields
  localparam int SAS_ADC_EN_BIT = 0;
  localparam int SAS_WIN_BIT    = 1;
  localparam int SAS_LJST_BIT   = 2;
  localparam int SAS_BUSY_BIT   = 4;
  localparam int SAS_DONE_BIT   = 5;

  // converter_config_reg fields
  localparam int SAS_GAIN_ACCESS_ENABLE_BIT = 0;
  localparam int SAS_RPT_LSB    = 1;
  localparam int SAS_DIV_LSB    = 3;

  // mode register fields
  localparam int SAS_TM_LSB    = 0;
  localparam int SAS_TK_LSB    = 2;
  localparam int SAS_BURST_BIT = 6;
  localparam int SAS_PWR_LSB   = 8;

  // reset values
  localparam logic [4:0]  SAS_DIV_RST  = 5'h1F;
  localparam logic [1:0]  SAS_TM_RST   = 2'h1;
  localparam logic [3:0]  SAS_TK_RST   = 4'h0;
  localparam logic [7:0]  SAS_PWR_RST  = 8'h0F;
  localparam logic [15:0] SAS_WGT_RST  = 16'hFFFF;
  localparam logic [15:0] SAS_WLT_RST  = 16'h0000;

  // gain registers, reached indirectly through the result registers
  localparam logic [7:0] SAS_GAIN_HI_IDX  = 8'h04;
  localparam logic [7:0] SAS_GAIN_LO_IDX  = 8'h07;
  localparam logic [7:0] SAS_GAIN_ADD_IDX = 8'h08;
  localparam logic [7:0] SAS_GAIN_HI_RST  = 8'hFC;
  localparam logic [3:0] SAS_GAIN_LO_RST  = 4'h0;
  localparam logic       SAS_GAIN_ADD_RST = 1'b1;

  // tracking_mode_select codes
  localparam logic [1:0] SAS_TM_PRE  = 2'h2;
  localparam logic [1:0] SAS_TM_POST = 2'h1;
  localparam logic [1:0] SAS_TM_DUAL = 2'h3;

  // timing counts
  localparam logic [7:0] SAS_SAR_LAST   = 8'h0C; // 13 sar ticks
  localparam logic [7:0] SAS_TRACK_XTRA = 8'h01; // 2 extra ticks
  localparam int         SAS_BURST_DIV  = 2;

  localparam logic [1:0] SAS_RESP_OK  = 2'h0;
  localparam logic [1:0] SAS_RESP_DEC = 2'h3;

  typedef enum logic [2:0] {
    SAS_IDLE, SAS_PWRUP, SAS_TRACK, SAS_SETUP, SAS_CONV, SAS_WRAP
  } sas_state_t;

  // samples per series for each repeat_count_field code
  function automatic logic [4:0] sas_samples(input logic [1:0] rpt);
    unique case (rpt)
      2'h0: sas_samples = 5'h01;
      2'h1: sas_samples = 5'h04;
      2'h2: sas_samples = 5'h08;
      2'h3: sas_samples = 5'h10;
    endcase
  endfunction

endpackage

/* File: sas_sar_model.sv */
// sas_sar_model: behavioural sar core that faces the sequencer.
// assumes the bench picks the code that is returned before each start.
`timescale 1ns/1ps
module sas_sar_model (
  input  wire logic        sys_clk_i,  // system clock
  input  wire logic        convert_i,  // core converting
  input  wire logic [11:0] code_i,     // code to return
  output logic [11:0]      sar_code_o  // code to sequencer
);
  logic [11:0] junk_q = 12'hA5A;

  // code is only valid while converting, churns otherwise
  always_ff @(posedge sys_clk_i) begin
    junk_q <= ~junk_q ^ 12'h5A5;
  end
  assign sar_code_o = convert_i ? code_i : junk_q;
endmodule

/* File: sas_seq.sv */
// sas_seq: converter sequencer with AXI4-Lite registers.
// assumes the start source and the sar core run on sys_clk_i.
// Function
// - subsystem clock is system clock, or burst oscillator in burst.
// - conversion clock is subsystem clock divided by the divider field plus one.
// - sequencer is always powering up, tracking, converting or idle.
// - pre-tracking outside burst converts immediately on start, no hardware tracking; in burst it tracks first.
// - post and dual tracking track for track time plus 2 ticks.
// - a conversion is 13 sar ticks plus 2 subsystem ticks.
// - burst wakes, takes the repeat count of samples, sleeps again.
// - in burst, adc_enable chooses powered down or enabled idle.
// - powered-down burst start waits power-up time before tracking.
// - burst runs the whole series per start; normal needs each start.
// - done flag sets only after the full repeat count.
// - window compare only after the full repeat count.
// - single sample gives a 12-bit unsigned code each conversion.
// - left_justify aligns the code left, unused bits zero.
// - repeat above one gives the right-aligned sum of samples.
// - sample count comes from repeat_count_field: 1, 4, 8 or 16.
// - selectable gain word is held and driven to the core.
// - tracking mode codes: pre 10, post 01, dual 11.
// - post tracking releases input after conversion; dual keeps it while adc_enable is set.
// - busy high during sequence; its fall sets the done flag only after the last sample.
// - with gain access on, result high is index, low is data.
`timescale 1ns/1ps
module sas_seq import sas_pkg::*; #(
  parameter int BURST_DIV = SAS_BURST_DIV
) (
  input  wire logic        sys_clk_i,       // 25 MHz system clock
  input  wire logic        rst_i,           // sync reset, high
  input  wire logic [7:0]  s_axi_awaddr_i,  // write address
  input  wire logic        s_axi_awvalid_i, // write address valid
  output logic             s_axi_awready_o, // write address ready
  input  wire logic [31:0] s_axi_wdata_i,   // write data
  input  wire logic [3:0]  s_axi_wstrb_i,   // write byte strobes
  input  wire logic        s_axi_wvalid_i,  // write data valid
  output logic             s_axi_wready_o,  // write data ready
  output logic [1:0]       s_axi_bresp_o,   // write response
  output logic             s_axi_bvalid_o,  // write response valid
  input  wire logic        s_axi_bready_i,  // write response ready
  input  wire logic [7:0]  s_axi_araddr_i,  // read address
  input  wire logic        s_axi_arvalid_i, // read address valid
  output logic             s_axi_arready_o, // read address ready
  output logic [31:0]      s_axi_rdata_o,   // read data
  output logic [1:0]       s_axi_rresp_o,   // read response
  output logic             s_axi_rvalid_o,  // read data valid
  input  wire logic        s_axi_rready_i,  // read data ready
  input  wire logic        cnv_start_i,     // convert start pulse
  input  wire logic [11:0] sar_code_i,      // code from sar core
  output logic             sar_power_o,     // core powered
  output logic             sar_track_o,     // input connected
  output logic             sar_convert_o,   // core converting
  output logic [12:0]      gain_word_o      // gain word and extra bit
);
  logic        adc_en_q, ljst_q, gain_access_enable_q, burst_q, gain_add_q;
  logic [1:0]  rpt_q, tm_q;
  logic [4:0]  div_q;
  logic [3:0]  tk_q, gain_lo_q;
  logic [7:0]  pwr_q, gain_idx_q, gain_hi_q, cnt_q;
  logic [15:0] result_q, acc_q, wgt_q, wlt_q;
  logic        busy_q, done_q, win_q, pend_q;
  logic [4:0]  smp_q;
  sas_state_t  state_q;
  logic        subsystem_clock_tick, sar_tick;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q, w_have_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == SAS_CTRL_OFS) || (a == SAS_CFG_OFS) ||
                (a == SAS_MODE_OFS) || (a == SAS_RESH_OFS) ||
                (a == SAS_RESL_OFS) || (a == SAS_WLIM_OFS);
  endfunction

  logic [31:0] ctrl_w, cfg_w, mode_w, wlim_w, wr_v;
  logic [31:0] mode_m, wlim_m;
  logic        wr_fire, last_smp, start_ev;
  logic [15:0] sum_v, res_v;

  always_comb begin
    ctrl_w = 32'h0;
    ctrl_w[SAS_ADC_EN_BIT] = adc_en_q;
    ctrl_w[SAS_WIN_BIT]    = win_q;
    ctrl_w[SAS_LJST_BIT]   = ljst_q;
    ctrl_w[SAS_BUSY_BIT]   = busy_q;
    ctrl_w[SAS_DONE_BIT]   = done_q;
    cfg_w  = 32'h0;
    cfg_w[SAS_GAIN_ACCESS_ENABLE_BIT]          = gain_access_enable_q;
    cfg_w[SAS_RPT_LSB +: 2]        = rpt_q;
    cfg_w[SAS_DIV_LSB +: 5]        = div_q;
    mode_w = 32'h0;
    mode_w[SAS_TM_LSB +: 2]        = tm_q;
    mode_w[SAS_TK_LSB +: 4]        = tk_q;
    mode_w[SAS_BURST_BIT]          = burst_q;
    mode_w[SAS_PWR_LSB +: 8]       = pwr_q;
    wlim_w = {wgt_q, wlt_q};
    mode_m = merge(mode_w, wdata_q, wstrb_q);
    wlim_m = merge(wlim_w, wdata_q, wstrb_q);
  end

  assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign wr_v     = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                               {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign start_ev = cnv_start_i ||
                    (wr_fire && awaddr_q == SAS_CTRL_OFS &&
                     wstrb_q[0] && wdata_q[SAS_BUSY_BIT]);
  assign last_smp = (smp_q + 5'h01) == sas_samples(rpt_q);
  assign sum_v    = ((smp_q == 5'h00) ? 16'h0000 : acc_q) +
                    {4'h0, sar_code_i};
  assign res_v    = (ljst_q && rpt_q == 2'h0) ? {sar_code_i, 4'h0} : sum_v;

  // write channel acceptance
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      awaddr_q        <= 8'h00;
      wdata_q         <= 32'h0;
      wstrb_q         <= 4'h0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= SAS_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q        <= s_axi_awaddr_i;
        aw_have_q       <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q        <= s_axi_wdata_i;
        wstrb_q        <= s_axi_wstrb_i;
        w_have_q       <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q      <= 1'b0;
        w_have_q       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= is_mapped(awaddr_q) ? SAS_RESP_OK : SAS_RESP_DEC;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= SAS_RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= is_mapped(s_axi_araddr_i) ? SAS_RESP_OK
                                                   : SAS_RESP_DEC;
      unique case (s_axi_araddr_i)
        SAS_CTRL_OFS: s_axi_rdata_o <= ctrl_w;
        SAS_CFG_OFS:  s_axi_rdata_o <= cfg_w;
        SAS_MODE_OFS: s_axi_rdata_o <= mode_w;
        SAS_RESH_OFS: s_axi_rdata_o <= {24'h0, result_q[15:8]};
        SAS_RESL_OFS: s_axi_rdata_o <= {24'h0, result_q[7:0]};
        SAS_WLIM_OFS: s_axi_rdata_o <= wlim_w;
        default:      s_axi_rdata_o <= 32'h0;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // software configuration
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      adc_en_q <= 1'b0;
      ljst_q   <= 1'b0;
      gain_access_enable_q <= 1'b0;
      rpt_q    <= 2'h0;
      div_q    <= SAS_DIV_RST;
      tm_q     <= SAS_TM_RST;
      tk_q     <= SAS_TK_RST;
      burst_q  <= 1'b0;
      pwr_q    <= SAS_PWR_RST;
      wgt_q    <= SAS_WGT_RST;
      wlt_q    <= SAS_WLT_RST;
    end else if (wr_fire) begin
      unique case (awaddr_q)
        SAS_CTRL_OFS: begin
          if (wstrb_q[0]) begin
            adc_en_q <= wdata_q[SAS_ADC_EN_BIT];
            ljst_q   <= wdata_q[SAS_LJST_BIT];
          end
        end
        SAS_CFG_OFS: begin
          if (wstrb_q[0]) begin
            gain_access_enable_q <= wdata_q[SAS_GAIN_ACCESS_ENABLE_BIT];
            rpt_q    <= wdata_q[SAS_RPT_LSB +: 2];
            div_q    <= wdata_q[SAS_DIV_LSB +: 5];
          end
        end
        SAS_MODE_OFS: begin
          tm_q    <= mode_m[SAS_TM_LSB +: 2];
          tk_q    <= mode_m[SAS_TK_LSB +: 4];
          burst_q <= mode_m[SAS_BURST_BIT];
          pwr_q   <= mode_m[SAS_PWR_LSB +: 8];
        end
        SAS_WLIM_OFS: begin
          {wgt_q, wlt_q} <= wlim_m;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gain_idx_q <= 8'h00;
      gain_hi_q  <= SAS_GAIN_HI_RST;
      gain_lo_q  <= SAS_GAIN_LO_RST;
      gain_add_q <= SAS_GAIN_ADD_RST;
    end else if (wr_fire && gain_access_enable_q && wstrb_q[0]) begin
      if (awaddr_q == SAS_RESH_OFS) begin
        gain_idx_q <= wdata_q[7:0];
      end else if (awaddr_q == SAS_RESL_OFS) begin
        unique case (gain_idx_q)
          SAS_GAIN_HI_IDX:  gain_hi_q  <= wr_v[7:0];
          SAS_GAIN_LO_IDX:  gain_lo_q  <= wr_v[7:4];
          SAS_GAIN_ADD_IDX: gain_add_q <= wr_v[0];
          default: begin
          end
        endcase
      end
    end
  end

  assign gain_word_o = {gain_hi_q, gain_lo_q, gain_add_q};

  sas_tick #(
    .BURST_DIV (BURST_DIV)
  ) u_tick (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .burst_i     (burst_q),
    .div_i       (div_q),
    .run_i       (state_q == SAS_CONV),
    .subsystem_clock_tick_o (subsystem_clock_tick),
    .sar_tick_o  (sar_tick)
  );

  // sequencer, one state at a time
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= SAS_IDLE;
      cnt_q   <= 8'h00;
      pend_q  <= 1'b0;
    end else begin
      if (start_ev && state_q == SAS_IDLE) pend_q <= 1'b1;
      unique case (state_q)
        SAS_IDLE: if (pend_q && subsystem_clock_tick) begin
          pend_q <= 1'b0;
          cnt_q  <= 8'h00;
          if (burst_q && !adc_en_q) state_q <= SAS_PWRUP;
          else if (tm_q == SAS_TM_PRE && !burst_q) state_q <= SAS_SETUP;
          else state_q <= SAS_TRACK;
        end
        SAS_PWRUP: if (subsystem_clock_tick) begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q >= pwr_q) begin
            cnt_q   <= 8'h00;
            state_q <= SAS_TRACK;
          end
        end
        SAS_TRACK: if (subsystem_clock_tick) begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == {4'h0, tk_q} + SAS_TRACK_XTRA) begin
            state_q <= SAS_SETUP;
          end
        end
        // start tick, 13 sar ticks, end tick
        SAS_SETUP: if (subsystem_clock_tick) begin
          cnt_q   <= 8'h00;
          state_q <= SAS_CONV;
        end
        SAS_CONV: if (sar_tick) begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == SAS_SAR_LAST) state_q <= SAS_WRAP;
        end
        SAS_WRAP: if (subsystem_clock_tick) begin
          cnt_q <= 8'h00;
          state_q <= (burst_q && !last_smp) ? SAS_TRACK : SAS_IDLE;
        end
      endcase
    end
  end

  // accumulate and publish at series end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      smp_q    <= 5'h00;
      acc_q    <= 16'h0000;
      result_q <= 16'h0000;
    end else if (state_q == SAS_WRAP && subsystem_clock_tick) begin
      acc_q <= sum_v;
      smp_q <= last_smp ? 5'h00 : smp_q + 5'h01;
      if (last_smp) result_q <= res_v;
    end
  end

  // busy and done, set beats clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      win_q  <= 1'b0;
    end else begin
      if (start_ev) busy_q <= 1'b1;
      else if (state_q == SAS_WRAP && subsystem_clock_tick &&
               !(burst_q && !last_smp)) busy_q <= 1'b0;
      if (wr_fire && awaddr_q == SAS_CTRL_OFS) begin
        if (wr_v[SAS_DONE_BIT]) done_q <= 1'b0;
        if (wr_v[SAS_WIN_BIT])  win_q  <= 1'b0;
      end
      if (state_q == SAS_WRAP && subsystem_clock_tick && last_smp) begin
        done_q <= 1'b1;
        if (res_v > wgt_q || res_v < wlt_q) win_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sar_power_o   <= 1'b0;
      sar_track_o   <= 1'b0;
      sar_convert_o <= 1'b0;
    end else begin
      sar_power_o   <= adc_en_q || (burst_q && state_q != SAS_IDLE);
      sar_convert_o <= state_q == SAS_SETUP || state_q == SAS_CONV ||
                       state_q == SAS_WRAP;
      sar_track_o   <= state_q == SAS_TRACK ||
                       (state_q == SAS_IDLE && adc_en_q &&
                        (tm_q == SAS_TM_PRE || tm_q == SAS_TM_DUAL));
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setup;
    state_q == SAS_SETUP && subsystem_clock_tick;
  endsequence

  a_subsystem_clock_source: assert property (
    !burst_q && $past(!burst_q) |-> subsystem_clock_tick)
    else $error("subsystem tick missing outside burst");
  a_pre_direct: assert property (
    state_q == SAS_IDLE && pend_q && subsystem_clock_tick && !burst_q &&
    tm_q == SAS_TM_PRE |=> state_q == SAS_SETUP)
    else $error("pre-tracking did not convert at once");
  a_track_len: assert property (
    state_q == SAS_TRACK && subsystem_clock_tick |-> cnt_q <= {4'h0, tk_q} + 8'h01)
    else $error("tracking ran past its time");
  a_conv_steps: assert property (
    s_setup |=> state_q == SAS_CONV && cnt_q == 8'h00)
    else $error("setup tick not followed by conversion");
  a_pwr_wait: assert property (
    state_q == SAS_IDLE && pend_q && subsystem_clock_tick && burst_q && !adc_en_q
    |=> state_q == SAS_PWRUP)
    else $error("powered-down burst skipped power-up");
  a_burst_chain: assert property (
    state_q == SAS_WRAP && subsystem_clock_tick && burst_q && !last_smp
    |=> state_q == SAS_TRACK && busy_q)
    else $error("burst series broken");
  a_done_full: assert property (
    $rose(done_q) |-> $past(state_q) == SAS_WRAP &&
    $past(smp_q) + 5'h01 == sas_samples($past(rpt_q)))
    else $error("done set before full count");
  a_result_hold: assert property (
    !$stable(result_q) |-> $past(state_q) == SAS_WRAP && $past(last_smp))
    else $error("result changed mid series");
  a_track_excl: assert property (
    !(sar_track_o && sar_convert_o))
    else $error("tracking and converting together");
endmodule

/* File: sas_tick.sv */
// sas_tick: subsystem clock enable and sar conversion clock enable.
// assumes one system clock; the burst oscillator is a free divider here.
`timescale 1ns/1ps
module sas_tick import sas_pkg::*; #(
  parameter int BURST_DIV = SAS_BURST_DIV
) (
  input  wire logic       sys_clk_i,   // system clock
  input  wire logic       rst_i,       // sync reset, high
  input  wire logic       burst_i,     // burst_enable
  input  wire logic [4:0] div_i,       // sar_clock_divider
  input  wire logic       run_i,       // converting, sar divider runs
  output logic            subsystem_clock_tick_o, // subsystem clock enable
  output logic            sar_tick_o   // conversion clock enable
);
  localparam logic [7:0] OSC_LAST = 8'(BURST_DIV - 1);

  logic [7:0] osc_q;
  logic [4:0] sar_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      osc_q       <= 8'h00;
      // burst is off after reset, so the tick follows every clock
      subsystem_clock_tick_o <= 1'b1;
    end else begin
      osc_q       <= (osc_q == OSC_LAST) ? 8'h00 : osc_q + 8'h01;
      subsystem_clock_tick_o <= !burst_i || (osc_q == OSC_LAST);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !run_i) begin
      sar_q      <= 5'h00;
      sar_tick_o <= 1'b0;
    end else if (subsystem_clock_tick_o) begin
      sar_q      <= (sar_q == div_i) ? 5'h00 : sar_q + 5'h01;
      sar_tick_o <= (sar_q == div_i);
    end else begin
      sar_tick_o <= 1'b0;
    end
  end
endmodule
